// >>> cpu_status_and_bus_cycles.sv
// Processor status, dedicated registers and asynchronous bus master
`timescale 1ns/1ps
`default_nettype none
module cpu_status_and_bus_cycles
  import cpu_core_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic [15:0] dal_in,
  output var  logic [15:0] dal_out,
  output var  logic [15:0] dal_oe,
  input  wire logic        sync_n_in,
  output var  logic        sync_n_out,
  output var  logic        sync_n_oe,
  input  wire logic        din_n_in,
  output var  logic        din_n_out,
  output var  logic        din_n_oe,
  input  wire logic        dout_n_in,
  output var  logic        dout_n_out,
  output var  logic        dout_n_oe,
  input  wire logic        wtbt_n_in,
  output var  logic        wtbt_n_out,
  output var  logic        wtbt_n_oe,
  input  wire logic        rply_n_in,
  output var  logic        rply_n_out,
  output var  logic        rply_n_oe,
  input  wire logic        irq_n_in,
  input  wire logic        dmr_n_in,
  output var  logic        iak_grant,
  output var  logic        dma_grant
);

  //////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    state_t      state;
    logic [15:0] psw;
    logic [15:0] sp;
    logic [15:0] pc;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic [15:0] opa;
    logic [15:0] opb;
    logic [15:0] result;
    logic [15:0] vector;
    cycle_t      kind;
    dest_t       dest;
    logic [15:0] cur_addr;
    logic [15:0] cur_wdata;
    logic [15:0] cap;
    logic        odd_err;
    logic [2:0]  trap_step;
    logic [15:0] trap_vec;
    logic [3:0]  cnt;
    logic        sync_o;
    logic        din_o;
    logic        dout_o;
    logic        wtbt_o;
    logic        iak_o;
    logic        dmg_o;
    logic [15:0] drive;
    logic [18:0] s1;
    logic [18:0] s2;
    logic [18:0] s3;
    logic [18:0] filt;
    logic [31:0] prdata;
  } core_t;

  core_t st;
  core_t next_st;

  // Bit order of the synchroniser vector: {dmr, irq, rply, dal}
  logic        rply_f;
  logic        irq_f;
  logic        dmr_f;
  logic [15:0] dal_f;
  logic        apb_wr;
  logic        apb_setup;
  logic        mapped;
  logic        cmd_go;
  logic        alu_go;
  logic [16:0] sum;

  assign rply_f    = st.filt[16];
  assign irq_f     = st.filt[17];
  assign dmr_f     = st.filt[18];
  assign dal_f     = st.filt[15:0];
  assign apb_setup = psel && !penable;
  assign apb_wr    = psel && penable && pwrite;
  assign cmd_go    = apb_wr && (paddr == OFF_CMD) && (st.state == S_IDLE)
                     && (st.trap_step == 3'd0);
  assign alu_go    = apb_wr && (paddr == OFF_ALU);

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a[1:0] == 2'b00) && (a <= OFF_VECTOR);
  endfunction

  // Places a byte on its lane: even address takes the low lane
  function automatic logic [15:0] lane(input logic [15:0] a,
                                       input logic [15:0] d);
    lane = a[0] ? {d[7:0], 8'h00} : {8'h00, d[7:0]};
  endfunction

  assign mapped  = is_mapped(paddr);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata  = st.prdata;

  // Wired-OR lines only ever pull low; the enable carries the asserted bit
  assign dal_out    = 16'h0000;
  assign dal_oe     = st.drive;
  assign sync_n_out = 1'b0;
  assign sync_n_oe  = st.sync_o;
  assign din_n_out  = 1'b0;
  assign din_n_oe   = st.din_o;
  assign dout_n_out = 1'b0;
  assign dout_n_oe  = st.dout_o;
  assign wtbt_n_out = 1'b0;
  assign wtbt_n_oe  = st.wtbt_o;
  assign rply_n_out = 1'b0;
  assign rply_n_oe  = 1'b0;
  assign iak_grant  = st.iak_o;
  assign dma_grant  = st.dmg_o;

  //////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_st = st;
    sum = 17'h00000;
    // Pin filter: a bit changes only when the second and third stages agree
    next_st.s1 = {~dmr_n_in, ~irq_n_in, ~rply_n_in, ~dal_in};
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.filt = (~(st.s2 ^ st.s3) & st.s3) | ((st.s2 ^ st.s3) & st.filt);

    if (apb_setup) begin
      next_st.prdata = 32'h00000000;
      case (paddr)
        OFF_PSW:    next_st.prdata[15:0] = st.psw;
        OFF_SP:     next_st.prdata[15:0] = st.sp;
        OFF_PC:     next_st.prdata[15:0] = st.pc;
        OFF_ADDR:   next_st.prdata[15:0] = st.addr;
        OFF_WDATA:  next_st.prdata[15:0] = st.wdata;
        OFF_RDATA:  next_st.prdata[15:0] = st.rdata;
        OFF_STATUS: next_st.prdata[5:0]  = {st.dmg_o,
                      st.addr <= VEC_TOP,
                      st.addr >= IO_PAGE_BASE,
                      st.odd_err, st.trap_step != 3'd0,
                      st.state != S_IDLE};
        OFF_OPA:    next_st.prdata[15:0] = st.opa;
        OFF_OPB:    next_st.prdata[15:0] = st.opb;
        OFF_RESULT: next_st.prdata[15:0] = st.result;
        OFF_VECTOR: next_st.prdata[15:0] = st.vector;
        default:    next_st.prdata = 32'h00000000;
      endcase
    end

    if (apb_wr) begin
      case (paddr)
        // Trap flag is kept: only a status word loaded through a trap vector changes it
        OFF_PSW:   next_st.psw = (pwdata[15:0] & PSW_WMASK)
                                 | (st.psw & ~PSW_WMASK);
        OFF_SP:    next_st.sp    = pwdata[15:0];
        OFF_PC:    next_st.pc    = pwdata[15:0];
        OFF_ADDR:  next_st.addr  = pwdata[15:0];
        OFF_WDATA: next_st.wdata = pwdata[15:0];
        OFF_OPA:   next_st.opa   = pwdata[15:0];
        OFF_OPB:   next_st.opb   = pwdata[15:0];
        default:   next_st.cnt   = st.cnt;
      endcase
    end

    // Register-only operation: no bus activity at all
    if (alu_go) begin
      case (alu_op_t'(pwdata[2:0]))
        ALU_ADD: sum = {1'b0, st.opa} + {1'b0, st.opb};
        ALU_SUB: sum = {1'b0, st.opa} - {1'b0, st.opb};
        ALU_AND: sum = {st.psw[PSW_C], st.opa & st.opb};
        ALU_OR:  sum = {st.psw[PSW_C], st.opa | st.opb};
        ALU_SHL: sum = {st.opa, 1'b0};
        ALU_SHR: sum = {st.opa[0], 1'b0, st.opa[15:1]};
        default: sum = {st.psw[PSW_C], st.opa};
      endcase
      next_st.result = sum[15:0];
      next_st.psw[PSW_Z] = (sum[15:0] == 16'h0000);
      next_st.psw[PSW_N] = sum[15];
      next_st.psw[PSW_C] = sum[16];
      case (alu_op_t'(pwdata[2:0]))
        ALU_ADD: next_st.psw[PSW_V] = (st.opa[15] == st.opb[15])
                                      && (sum[15] != st.opa[15]);
        ALU_SUB: next_st.psw[PSW_V] = (st.opa[15] != st.opb[15])
                                      && (sum[15] != st.opa[15]);
        default: next_st.psw[PSW_V] = 1'b0;
      endcase
    end

    case (st.state)
      S_IDLE: begin
        next_st.cnt = 4'h0;
        if (dmr_f && st.trap_step == 3'd0) begin
          next_st.dmg_o = 1'b1;
          next_st.state = S_DMA;
        end else if (st.trap_step != 3'd0) begin
          // Trap: push status, push counter, then load both from the vector
          next_st.state = S_ADDR;
          next_st.trap_step = (st.trap_step == 3'd4) ? 3'd0
                              : st.trap_step + 3'd1;
          case (st.trap_step)
            3'd1, 3'd2: begin
              next_st.sp = st.sp - WORD_STEP;
              next_st.cur_addr = st.sp - WORD_STEP;
              next_st.cur_wdata = (st.trap_step == 3'd1) ? st.psw : st.pc;
              next_st.kind = read_then_word_write_cycle;
              next_st.dest = DST_NONE;
            end
            3'd3: begin
              next_st.cur_addr = st.trap_vec;
              next_st.kind = word_read_cycle;
              next_st.dest = DST_PC;
            end
            default: begin
              next_st.cur_addr = st.trap_vec + WORD_STEP;
              next_st.kind = word_read_cycle;
              next_st.dest = DST_PSW;
            end
          endcase
        end else if (irq_f && !st.psw[PSW_PRIO]) begin
          next_st.din_o = 1'b1;
          next_st.iak_o = 1'b1;
          next_st.state = S_IAK;
        end else if (cmd_go) begin
          next_st.odd_err = 1'b0;
          next_st.cur_addr = st.addr;
          next_st.cur_wdata = st.wdata;
          next_st.dest = DST_RDATA;
          case (cmd_t'(pwdata[2:0]))
            CMD_WORD_READ, CMD_READ_WORD_WRITE: begin
              next_st.kind = (cmd_t'(pwdata[2:0]) == CMD_WORD_READ)
                             ? word_read_cycle : read_then_word_write_cycle;
              if (st.addr[0])
                next_st.odd_err = 1'b1;
              else
                next_st.state = S_ADDR;
            end
            CMD_READ_BYTE_WRITE: begin
              next_st.kind = read_then_byte_write_cycle;
              next_st.state = S_ADDR;
            end
            CMD_PUSH: begin
              next_st.sp = st.sp - WORD_STEP;
              next_st.cur_addr = st.sp - WORD_STEP;
              next_st.kind = read_then_word_write_cycle;
              next_st.dest = DST_NONE;
              next_st.state = S_ADDR;
            end
            CMD_FETCH: begin
              next_st.pc = st.pc + WORD_STEP;
              next_st.cur_addr = st.pc;
              next_st.kind = word_read_cycle;
              next_st.state = S_ADDR;
            end
            CMD_INSTR_DONE: begin
              if (st.psw[PSW_T]) begin
                next_st.trap_step = 3'd1;
                next_st.trap_vec = STEP_VEC;
              end
            end
            default: next_st.state = S_IDLE;
          endcase
        end
      end
      S_ADDR: begin
        next_st.sync_o = 1'b1;
        next_st.drive = st.cur_addr;
        next_st.cnt = st.cnt + 4'h1;
        // First cycle here raises sync and drives the address together; the address then stands
        // for the full count before the data phase opens
        if (st.cnt == ADDR_CYCLES) begin
          next_st.drive = 16'h0000;
          next_st.din_o = 1'b1;
          next_st.state = S_DIN;
        end
      end
      S_DIN: begin
        // No timeout: the slave sets the pace
        if (rply_f) begin
          next_st.cap = dal_f;
          next_st.din_o = 1'b0;
          next_st.state = S_DIN_END;
        end
      end
      S_DIN_END: begin
        if (!rply_f) begin
          if (st.kind == word_read_cycle) begin
            next_st.sync_o = 1'b0;
            next_st.state = S_IDLE;
            case (st.dest)
              DST_RDATA: next_st.rdata = st.cap;
              DST_PC:    next_st.pc = st.cap;
              DST_PSW:   next_st.psw = st.cap;
              default:   next_st.rdata = st.rdata;
            endcase
          end else begin
            next_st.dout_o = 1'b1;
            next_st.rdata = (st.dest == DST_RDATA) ? st.cap : st.rdata;
            if (st.kind == read_then_byte_write_cycle) begin
              next_st.wtbt_o = 1'b1;
              next_st.drive = lane(st.cur_addr, st.cur_wdata);
            end else begin
              next_st.drive = st.cur_wdata;
            end
            next_st.state = S_DOUT;
          end
        end
      end
      S_DOUT: begin
        if (rply_f) begin
          next_st.dout_o = 1'b0;
          next_st.wtbt_o = 1'b0;
          next_st.drive = 16'h0000;
          next_st.state = S_DOUT_END;
        end
      end
      S_DOUT_END: begin
        if (!rply_f) begin
          next_st.sync_o = 1'b0;
          next_st.state = S_IDLE;
        end
      end
      S_IAK: begin
        if (rply_f) begin
          next_st.vector = dal_f & VEC_MASK;
          next_st.din_o = 1'b0;
          next_st.iak_o = 1'b0;
          next_st.state = S_IAK_END;
        end
      end
      S_IAK_END: begin
        if (!rply_f) begin
          next_st.trap_step = 3'd1;
          next_st.trap_vec = st.vector;
          next_st.state = S_IDLE;
        end
      end
      S_DMA: begin
        if (!dmr_f) begin
          next_st.dmg_o = 1'b0;
          next_st.state = S_IDLE;
        end
      end
      default: next_st.state = S_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.state <= S_IDLE;
      st.psw <= PSW_RESET;
      st.sp <= SP_RESET;
      st.pc <= PC_RESET;
    end else begin
      st <= next_st;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence addr_phase;
    (st.sync_o && st.drive == st.cur_addr && !st.din_o)[*6];
  endsequence

  chk_push_sp_dec: assert property (
    cmd_go && pwdata[2:0] == 3'd3 |=> st.sp == $past(st.sp) - 16'h0002
      && st.cur_addr == st.sp)
    else $error("push did not lower stack pointer by two");
  chk_fetch_pc_inc: assert property (
    cmd_go && pwdata[2:0] == 3'd4 |=> st.pc == $past(st.pc) + 16'h0002
      && st.cur_addr == $past(st.pc))
    else $error("fetch did not advance program counter");
  chk_alu_no_bus: assert property (
    alu_go && st.state == S_IDLE && !cmd_go && !dmr_f && !irq_f
      && st.trap_step == 3'd0 |=> st.state == S_IDLE && !st.sync_o)
    else $error("register operation started a bus cycle");
  chk_odd_word_refused: assert property (
    cmd_go && pwdata[2:1] == 2'b00 && st.addr[0] |=>
      st.odd_err && st.state == S_IDLE)
    else $error("odd word address not refused");
  chk_addr_phase_len: assert property (
    $rose(st.sync_o) |-> addr_phase ##1 (st.din_o && st.drive == 16'h0000))
    else $error("address phase length wrong");
  chk_irq_masked: assert property (
    st.psw[PSW_PRIO] && st.state == S_IDLE |=> !st.iak_o)
    else $error("interrupt acknowledged while masked");
  chk_zero_flag: assert property (
    alu_go |=> st.psw[PSW_Z] == (st.result == 16'h0000)
      && st.psw[PSW_N] == st.result[15])
    else $error("zero or negative flag wrong");
  chk_t_protected: assert property (
    apb_wr && paddr == OFF_PSW && st.state != S_DIN_END |=>
      st.psw[PSW_T] == $past(st.psw[PSW_T]))
    else $error("trap flag changed by direct write");
  chk_wait_reply: assert property (
    st.state == S_DIN && !rply_f |=> st.state == S_DIN && st.din_o)
    else $error("read data phase ended without reply");
  chk_one_master: assert property (
    !(st.dmg_o && (st.sync_o || st.din_o || st.dout_o)))
    else $error("processor drives bus while DMA granted");
  chk_byte_lane: assert property (
    $rose(st.wtbt_o) |-> st.drive == (st.cur_addr[0]
      ? {st.cur_wdata[7:0], 8'h00} : {8'h00, st.cur_wdata[7:0]}))
    else $error("byte placed on wrong lane");
  chk_step_vector: assert property (
    st.state == S_IDLE && st.trap_step == 3'd3 |=> st.cur_addr == st.trap_vec
      && st.dest == DST_PC)
    else $error("trap did not read the vector location");

endmodule // cpu_status_and_bus_cycles
`default_nettype wire

// >>> cpu_core_pkg.sv
// Constants, register map and types for the processor status and bus block
//
// Contract
// - Stack pointer always holds address of the most recently pushed entry.
// - Program counter holds address of the next instruction; addressing only.
// - Register operations use no bus cycle; memory and device accesses do.
// - Bus cycles: word read, read then word write, read then byte write.
// - Address space is 64K bytes; top 4096 bytes are peripheral registers (code: page starts at E000, the top 8192 bytes).
// - Word accesses use even addresses only; bytes use any address.
// - Low byte lives at the even address, high byte at the odd one.
// - Byte addresses zero to octal 376 hold trap and interrupt vectors.
// - Status bit 7 set blocks external interrupt requests.
// - Device interrupts are serviced at one priority level only.
// - Zero flag is set when the last result equals zero.
// - Negative flag is set when the last result is negative.
// - Carry flag set on carry out of MSB or a one shifted out.
// - Overflow flag set on signed arithmetic overflow, cleared otherwise.
// - Flags update after single and double operand arithmetic or logic.
// - Trap flag cannot be written directly; only a status pop changes it (code: only a status word loaded through a trap vector changes it).
// - Trap flag set causes a trap through location 14 after the instruction.
// - The single-step trap loads the new status word from location 16.
// - Address and data share 16 lines; address is driven a fixed time first.
// - Bus data and control lines are wired-OR and asserted low.
// - One bus master at a time; processor arbitrates and may grant DMA.
package cpu_core_pkg;
  // APB register offsets
  localparam logic [7:0] OFF_PSW    = 8'h00;
  localparam logic [7:0] OFF_SP     = 8'h04;
  localparam logic [7:0] OFF_PC     = 8'h08;
  localparam logic [7:0] OFF_ADDR   = 8'h0C;
  localparam logic [7:0] OFF_WDATA  = 8'h10;
  localparam logic [7:0] OFF_RDATA  = 8'h14;
  localparam logic [7:0] OFF_CMD    = 8'h18;
  localparam logic [7:0] OFF_STATUS = 8'h1C;
  localparam logic [7:0] OFF_OPA    = 8'h20;
  localparam logic [7:0] OFF_OPB    = 8'h24;
  localparam logic [7:0] OFF_ALU    = 8'h28;
  localparam logic [7:0] OFF_RESULT = 8'h2C;
  localparam logic [7:0] OFF_VECTOR = 8'h30;
  // Status word fields
  localparam int PSW_C    = 0;
  localparam int PSW_V    = 1;
  localparam int PSW_Z    = 2;
  localparam int PSW_N    = 3;
  localparam int PSW_T    = 4;
  localparam int PSW_PRIO = 7;
  localparam logic [15:0] PSW_WMASK = 16'h008F;
  localparam logic [15:0] PSW_RESET = 16'h0000;
  localparam logic [15:0] SP_RESET  = 16'h0000;
  localparam logic [15:0] PC_RESET  = 16'h0000;
  // Address map
  localparam logic [15:0] IO_PAGE_BASE = 16'hE000;
  localparam logic [15:0] VEC_TOP      = 16'h00FE;
  localparam logic [15:0] VEC_MASK     = 16'h00FE;
  localparam logic [15:0] STEP_VEC     = 16'h000C;
  localparam logic [15:0] WORD_STEP    = 16'h0002;
  // Address phase time
  localparam int CLK_PERIOD_NS = 25;
  localparam int ADDR_TIME_NS  = 150;
  localparam int ADDR_CYCLES_I =
    (ADDR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] ADDR_CYCLES = 4'(ADDR_CYCLES_I);
  // Commands, ALU operations, sequencer states
  typedef enum logic [2:0] {
    CMD_WORD_READ, CMD_READ_WORD_WRITE, CMD_READ_BYTE_WRITE,
    CMD_PUSH, CMD_FETCH, CMD_INSTR_DONE, CMD_NOP6, CMD_NOP7
  } cmd_t;
  typedef enum logic [2:0] {
    ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_SHL, ALU_SHR, ALU_NOP6, ALU_NOP7
  } alu_op_t;
  typedef enum logic [1:0] {
    word_read_cycle, read_then_word_write_cycle, read_then_byte_write_cycle
  } cycle_t;
  typedef enum logic [1:0] {DST_NONE, DST_RDATA, DST_PC, DST_PSW} dest_t;
  typedef enum logic [3:0] {
    S_IDLE, S_ADDR, S_DIN, S_DIN_END, S_DOUT, S_DOUT_END, S_IAK, S_IAK_END,
    S_DMA
  } state_t;
endpackage

// >>> bus_slave_model.sv
// Memory and interrupting device on the far side of the system bus
`timescale 1ns/1ps
`default_nettype none
module bus_slave_model (
  input  wire logic        clk,
  input  wire logic [15:0] dal_n,
  input  wire logic        sync_n,
  input  wire logic        din_n,
  input  wire logic        dout_n,
  input  wire logic        wtbt_n,
  input  wire logic        iak,
  input  wire logic [15:0] vec,
  input  wire logic [3:0]  delay,
  input  wire logic        irq_req,
  output var  logic        iak_pass,
  output var  logic [15:0] dal_pull,
  output var  logic        rply_pull
);
  // Only 256 words: higher addresses alias onto them
  logic [15:0] mem [0:255];
  logic [15:0] adr;
  logic        sync_q;
  logic [3:0]  cnt;
  wire  logic  req;
  assign req = !din_n || !dout_n;
  // A device that wants service keeps the grant for itself
  assign iak_pass = iak && !irq_req;
  initial begin
    dal_pull = 16'h0000;
    rply_pull = 1'b0;
    sync_q = 1'b0;
  end
  always @(posedge clk) begin
    sync_q <= !sync_n;
    if (!sync_n && !sync_q) adr <= ~dal_n;
    if (!req) begin
      // Released lines go back to the pull-up level
      cnt <= 4'h0;
      rply_pull <= 1'b0;
      dal_pull <= 16'h0000;
    end else if (cnt != delay) begin
      cnt <= cnt + 4'h1;
    end else if (!rply_pull) begin
      rply_pull <= 1'b1;
      if (!din_n) dal_pull <= iak ? vec : mem[adr[8:1]];
      else if (wtbt_n) mem[adr[8:1]] <= ~dal_n;
      else if (adr[0]) mem[adr[8:1]][15:8] <= ~dal_n[15:8];
      else mem[adr[8:1]][7:0] <= ~dal_n[7:0];
    end
  end
endmodule // bus_slave_model
`default_nettype wire

// >>> cpu_status_and_bus_cycles_tb_top.sv
// Testbench for the processor status and bus cycle block
`timescale 1ns/1ps
`default_nettype none
module cpu_status_and_bus_cycles_tb_top;
  import cpu_core_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [15:0] dal_out, dal_oe, dal_pull, vec;
  logic sync_n_out, sync_n_oe, din_n_out, din_n_oe, dout_n_out, dout_n_oe;
  logic wtbt_n_out, wtbt_n_oe, rply_n_out, rply_n_oe, rply_pull;
  logic irq_n, dmr_n, iak_grant, dma_grant, iak_pass;
  logic [3:0] delay;
  int n_errors, cmp_count, i;
  wire logic [15:0] dal = ~(dal_oe | dal_pull);
  wire logic rply_n = ~(rply_n_oe | rply_pull);
  cpu_status_and_bus_cycles uut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .dal_in(dal), .dal_out,
    .dal_oe, .sync_n_in(~sync_n_oe), .sync_n_out, .sync_n_oe,
    .din_n_in(~din_n_oe), .din_n_out, .din_n_oe, .dout_n_in(~dout_n_oe),
    .dout_n_out, .dout_n_oe, .wtbt_n_in(~wtbt_n_oe), .wtbt_n_out,
    .wtbt_n_oe, .rply_n_in(rply_n), .rply_n_out, .rply_n_oe,
    .irq_n_in(irq_n), .dmr_n_in(dmr_n), .iak_grant, .dma_grant);
  bus_slave_model slv (.clk(pclk), .dal_n(dal), .sync_n(~sync_n_oe),
    .din_n(~din_n_oe), .dout_n(~dout_n_oe), .wtbt_n(~wtbt_n_oe),
    .iak(iak_grant), .vec, .delay, .irq_req(~irq_n), .iak_pass,
    .dal_pull, .rply_pull);
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      n_errors++;
      $display("FAIL %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(r, e);
  endtask
  task idle(input int n);
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (n) @(posedge pclk);
  endtask
  task wait_idle;
    for (i = 0; i < 400; i++) begin
      apb(1'b0, OFF_STATUS, 32'h0);
      if (r[1:0] === 2'b00) break;
    end
    chk({30'h0, r[1:0]}, 32'h0);
  endtask
  task run(input logic [2:0] c);
    wr(OFF_CMD, {29'h0, c});
    idle(2);
    wait_idle;
  endtask
  task complete_run;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #(25 * 20000);
    n_errors++;
    complete_run;
  end
  ////////////////////////////////////////////////////////////////////////////
  // ALU table: op, a, b, result, flags, flag mask (borrow sense left open)
  logic [15:0] t [7][6] = '{
    '{16'h0, 16'h7FFF, 16'h1, 16'h8000, 16'hA, 16'hF},
    '{16'h1, 16'h5, 16'h5, 16'h0, 16'h4, 16'hE},
    '{16'h4, 16'h8000, 16'h0, 16'h0, 16'h5, 16'hF},
    '{16'h2, 16'hF0F0, 16'h0FF0, 16'h00F0, 16'h1, 16'hF},
    '{16'h3, 16'h8000, 16'h1, 16'h8001, 16'h9, 16'hF},
    '{16'h5, 16'h1, 16'h0, 16'h0, 16'h5, 16'hF},
    '{16'h0, 16'hFFFF, 16'h1, 16'h0, 16'h5, 16'hF}};
  initial begin
    {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
    {irq_n, dmr_n, delay, vec} = {2'b11, 4'h0, 16'h0030};
    slv.mem[8'h10] = 16'h1111;
    slv.mem[8'h20] = 16'h5555;
    {slv.mem[8'h18], slv.mem[8'h19]} = {16'h0200, 16'h0013};
    {slv.mem[8'h06], slv.mem[8'h07]} = {16'h0300, 16'h0000};
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rc(OFF_PSW, 32'h0);
    rc(OFF_SP, 32'h0);
    rc(OFF_PC, 32'h0);
    rc(8'hFC, 32'h0);
    chk({31'h0, err}, 32'h1);
    wr(OFF_PSW, 32'hFFFF);
    rc(OFF_PSW, 32'h008F);
    for (int k = 0; k < 7; k++) begin
      wr(OFF_OPA, {16'h0, t[k][1]});
      wr(OFF_OPB, {16'h0, t[k][2]});
      wr(OFF_ALU, {16'h0, t[k][0]});
      idle(1);
      rc(OFF_RESULT, {16'h0, t[k][3]});
      apb(1'b0, OFF_PSW, 32'h0);
      chk(r & t[k][5], t[k][4]);
      chk({31'h0, sync_n_oe}, 32'h0);
    end
    wr(OFF_ADDR, 32'h0020);
    run(3'h0);
    rc(OFF_RDATA, 32'h1111);
    delay <= 4'h5;
    wr(OFF_ADDR, 32'h0022);
    wr(OFF_WDATA, 32'hBEEF);
    run(3'h1);
    chk({16'h0, slv.mem[8'h11]}, 32'hBEEF);
    wr(OFF_ADDR, 32'h0023);
    wr(OFF_WDATA, 32'hABAB);
    run(3'h2);
    chk({16'h0, slv.mem[8'h11]}, 32'hABEF);
    wr(OFF_ADDR, 32'h0021);
    run(3'h0);
    chk({31'h0, r[2]}, 32'h1);
    for (int k = 0; k < 4; k++) begin
      wr(OFF_ADDR, k[1] ? (k[0] ? 32'h0100 : 32'h00FE)
                         : (k[0] ? 32'hDFFE : 32'hE000));
      apb(1'b0, OFF_STATUS, 32'h0);
      chk({30'h0, r[4:3]},
          k == 0 ? 32'h1 : k == 2 ? 32'h2 : 32'h0);
    end
    wr(OFF_SP, 32'h0100);
    wr(OFF_WDATA, 32'h1234);
    run(3'h3);
    rc(OFF_SP, 32'h00FE);
    chk({16'h0, slv.mem[8'h7F]}, 32'h1234);
    wr(OFF_PC, 32'h0040);
    run(3'h4);
    rc(OFF_PC, 32'h0042);
    rc(OFF_RDATA, 32'h5555);
    wr(OFF_PSW, 32'h0080);
    irq_n <= 1'b0;
    idle(20);
    chk({31'h0, iak_grant}, 32'h0);
    wr(OFF_PSW, 32'h0000);
    idle(1);
    for (i = 0; i < 100 && iak_grant !== 1'b1; i++) @(posedge pclk);
    chk({31'h0, iak_grant}, 32'h1);
    chk({31'h0, iak_pass}, 32'h0);
    irq_n <= 1'b1;
    wait_idle;
    rc(OFF_PC, 32'h0200);
    rc(OFF_PSW, 32'h0013);
    rc(OFF_SP, 32'h00FA);
    chk({slv.mem[8'h7E], slv.mem[8'h7D]}, 32'h00000042);
    rc(OFF_VECTOR, 32'h0030);
    run(3'h5);
    rc(OFF_PC, 32'h0300);
    rc(OFF_PSW, 32'h0000);
    chk({slv.mem[8'h7C], slv.mem[8'h7B]}, 32'h00130200);
    dmr_n <= 1'b0;
    idle(1);
    for (i = 0; i < 50 && dma_grant !== 1'b1; i++) @(posedge pclk);
    chk({30'h0, dma_grant, sync_n_oe}, 32'h2);
    dmr_n <= 1'b1;
    for (i = 0; i < 50 && dma_grant !== 1'b0; i++) @(posedge pclk);
    chk({31'h0, dma_grant}, 32'h0);
    complete_run;
  end
endmodule // cpu_status_and_bus_cycles_tb_top
`default_nettype wire
